// ==== rtl/csof_regs.sv ====
// Purpose: clock select, history and output format register bank with its decode
// Assumes: register port driven by the serial control logic on ref_clk; select pin is asynchronous
// Notes:   read data appears one cycle after rd_en; unmapped offsets read 8'h00
`timescale 1ns/10ps
module csof_regs (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // register port
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    input  wire logic [7:0]        addr,
    input  wire logic [7:0]        wr_data,
    output logic      [7:0]        rd_data,
    // selection controls held elsewhere in the bank
    input  wire logic              pin_select_control,
    input  wire logic [1:0]        register_input_choice,
    input  wire logic [1:0]        first_priority_input,
    input  wire logic              force_hold,
    input  wire logic              select_pin,       // external pin, 1 = input two
    input  wire logic              input_one_bad,
    input  wire logic              input_two_bad,
    // generated output clocks before the hold stage
    input  wire logic              output_one_src,
    input  wire logic              output_two_src,
    // selection results
    output logic                   use_input_two,
    output logic                   digital_hold,
    // history settings
    output logic      [4:0]        history_delay,
    output logic      [4:0]        history_averaging_time,
    // output format decode
    output logic      [2:0]        out1_format,
    output logic      [2:0]        out2_format,
    output logic                   out1_enable,
    output logic                   out2_enable,
    output logic      [1:0]        out1_drive,
    output logic      [1:0]        out2_drive,
    output logic      [2:0]        offset_alarm_reference,
    // held clock outputs
    output logic                   output_one,
    output logic                   output_two
);
    import csof_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************

    // merge a write into a register, keeping reserved bits
    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction : merge

    // output is live only for a defined, non-disable format
    function automatic logic fmt_live(input logic [2:0] fmt);
        case (fmt)
            FMT_CMOS, FMT_LVDS_LOW, FMT_LVPECL, FMT_CML, FMT_LVDS: fmt_live = 1'b1;
            default: fmt_live = 1'b0; // disable and reserved codes
        endcase
    endfunction : fmt_live

    // drive strength reaches the buffer only in CMOS format
    function automatic logic [1:0] fmt_drive(input logic [2:0] fmt, input logic [1:0] drv);
        fmt_drive = (fmt == FMT_CMOS) ? drv : 2'h0;
    endfunction : fmt_drive

    // ************************************************************
    // register file
    // ************************************************************
    logic [7:0] method_reg,  method_next;      // selection method, history delay
    logic [7:0] drive_reg,   drive_next;       // single-ended drive
    logic [7:0] format_reg,  format_next;      // output formats
    logic [7:0] aref_reg,    aref_next;        // alarm reference
    logic [7:0] hold_reg,    hold_next;        // static hold codes
    logic [7:0] avg_reg,     avg_next;         // history averaging
    logic [7:0] rd_reg,      rd_next;          // read data

    // writes land only on writable bits; reads are registered
    always_comb begin
        method_next = method_reg;
        drive_next  = drive_reg;
        format_next = format_reg;
        aref_next   = aref_reg;
        hold_next   = hold_reg;
        avg_next    = avg_reg;
        rd_next     = rd_reg;
        if (wr_en) begin
            case (addr)
                OFS_SEL_METHOD:  method_next = merge(method_reg, wr_data, WR_SEL_METHOD);
                OFS_CMOS_DRIVE:  drive_next  = merge(drive_reg, wr_data, WR_CMOS_DRIVE);
                OFS_OUT_FORMAT:  format_next = merge(format_reg, wr_data, WR_OUT_FORMAT);
                OFS_ALARM_REF:   aref_next   = merge(aref_reg, wr_data, WR_ALARM_REF);
                OFS_STATIC_HOLD: hold_next   = merge(hold_reg, wr_data, WR_STATIC_HOLD);
                OFS_HISTORY_AVERAGING_TIME:    avg_next    = merge(avg_reg, wr_data, WR_HISTORY_AVERAGING_TIME);
                default: begin
                    // unmapped offsets ignore writes
                end
            endcase
        end
        if (rd_en) begin
            case (addr)
                OFS_SEL_METHOD:  rd_next = method_reg;
                OFS_CMOS_DRIVE:  rd_next = drive_reg;
                OFS_OUT_FORMAT:  rd_next = format_reg;
                OFS_ALARM_REF:   rd_next = aref_reg;
                OFS_STATIC_HOLD: rd_next = hold_reg;
                OFS_HISTORY_AVERAGING_TIME:    rd_next = avg_reg;
                default:         rd_next = 8'h00;
            endcase
        end
    end

    // register storage
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            method_reg <= RST_SEL_METHOD;
            drive_reg  <= RST_CMOS_DRIVE;
            format_reg <= RST_OUT_FORMAT;
            aref_reg   <= RST_ALARM_REF;
            hold_reg   <= RST_STATIC_HOLD;
            avg_reg    <= RST_HISTORY_AVERAGING_TIME;
            rd_reg     <= 8'h00;
        end else begin
            method_reg <= method_next;
            drive_reg  <= drive_next;
            format_reg <= format_next;
            aref_reg   <= aref_next;
            hold_reg   <= hold_next;
            avg_reg    <= avg_next;
            rd_reg     <= rd_next;
        end
    end

    // ************************************************************
    // field extraction
    // ************************************************************
    logic [1:0] method_f;                      // selection method
    logic [2:0] fmt1_f;                        // first output format
    logic [2:0] fmt2_f;                        // second output format
    logic [1:0] drv_f;                         // drive strength
    logic [2:0] aref_f;                        // alarm reference code
    assign method_f = method_reg[POS_METHOD +: 2];
    assign fmt1_f   = format_reg[POS_OUT1_FMT +: 3];
    assign fmt2_f   = format_reg[POS_OUT2_FMT +: 3];
    assign drv_f    = drive_reg[POS_DRIVE +: 2];
    assign aref_f   = aref_reg[POS_ALARM_REF +: 3];

    // ************************************************************
    // select pin synchroniser
    // ************************************************************
    logic pin_meta_reg;                        // first stage, read only by second
    logic pin_sync_reg;                        // safe to use

    // two flops before the pin reaches any logic
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= select_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ************************************************************
    // input selection
    // ************************************************************
    csof_sel_t sel_reg, sel_next;              // active input or hold
    logic      prio_two;                       // input two ranks first
    logic      best_ok;                        // first-ranked input is good
    logic      other_ok;                       // second-ranked input is good
    csof_sel_t best_sel;                       // first-ranked input
    csof_sel_t other_sel;                      // second-ranked input

    // second priority is the input the first does not name
    assign prio_two  = (first_priority_input == CHOICE_IN2);
    assign best_sel  = prio_two ? SEL_IN2 : SEL_IN1;
    assign other_sel = prio_two ? SEL_IN1 : SEL_IN2;
    assign best_ok   = prio_two ? !input_two_bad : !input_one_bad;
    assign other_ok  = prio_two ? !input_one_bad : !input_two_bad;

    // reserved codes keep the present choice rather than guess one
    always_comb begin
        sel_next = sel_reg;
        if (force_hold) begin
            sel_next = SEL_HOLD;
        end else begin
            case (method_f)
                METHOD_MANUAL: begin
                    if (pin_select_control) begin
                        sel_next = pin_sync_reg ? SEL_IN2 : SEL_IN1;
                    end else if (register_input_choice == CHOICE_IN1) begin
                        sel_next = SEL_IN1;
                    end else if (register_input_choice == CHOICE_IN2) begin
                        sel_next = SEL_IN2;
                    end
                end
                METHOD_NONREVERT: begin
                    // stay on a good input; move only when it fails
                    if (sel_reg == SEL_IN1 && !input_one_bad) sel_next = SEL_IN1;
                    else if (sel_reg == SEL_IN2 && !input_two_bad) sel_next = SEL_IN2;
                    else if (best_ok) sel_next = best_sel;
                    else if (other_ok) sel_next = other_sel;
                    else sel_next = SEL_HOLD;
                end
                METHOD_REVERT: begin
                    // always return to the highest-ranked good input
                    if (best_ok) sel_next = best_sel;
                    else if (other_ok) sel_next = other_sel;
                    else sel_next = SEL_HOLD;
                end
                default: begin
                    sel_next = sel_reg;
                end
            endcase
        end
    end

    // ************************************************************
    // output decode registers
    // ************************************************************
    logic       in2_reg,  hold_out_reg;        // selection flags
    logic       en1_reg,  en2_reg;             // output enables
    logic [1:0] drv1_reg, drv2_reg;            // drive per output
    logic [2:0] aref_oh_reg, aref_oh_next;     // one-hot alarm reference

    // reserved reference codes select nothing
    always_comb begin
        case (aref_f)
            AREF_EXTERNAL: aref_oh_next = 3'h1;
            AREF_IN1:      aref_oh_next = 3'h2;
            AREF_IN2:      aref_oh_next = 3'h4;
            default:       aref_oh_next = 3'h0;
        endcase
    end

    // selection state and decoded outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sel_reg      <= SEL_IN1;
            in2_reg      <= 1'b0;
            hold_out_reg <= 1'b0;
            en1_reg      <= 1'b0;
            en2_reg      <= 1'b0;
            drv1_reg     <= 2'h0;
            drv2_reg     <= 2'h0;
            aref_oh_reg  <= 3'h0;
        end else begin
            sel_reg      <= sel_next;
            in2_reg      <= (sel_next == SEL_IN2);
            hold_out_reg <= (sel_next == SEL_HOLD);
            en1_reg      <= fmt_live(fmt1_f);
            en2_reg      <= fmt_live(fmt2_f);
            drv1_reg     <= fmt_drive(fmt1_f, drv_f);
            drv2_reg     <= fmt_drive(fmt2_f, drv_f);
            aref_oh_reg  <= aref_oh_next;
        end
    end

    // ************************************************************
    // glitch-free hold stages
    // ************************************************************
    csof_out_hold u_hold_one (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .src_clk   (output_one_src),
        .hold_code (hold_reg[POS_OUT1_HOLD +: 2]),
        .out_level (output_one),
        .holding   ()
    );

    csof_out_hold u_hold_two (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .src_clk   (output_two_src),
        .hold_code (hold_reg[POS_OUT2_HOLD +: 2]),
        .out_level (output_two),
        .holding   ()
    );

    // ************************************************************
    // output assignments, all from flops
    // ************************************************************
    assign rd_data                = rd_reg;
    assign use_input_two          = in2_reg;
    assign digital_hold           = hold_out_reg;
    assign history_delay          = method_reg[POS_HISTORY_DELAY +: 5];
    assign history_averaging_time = avg_reg[POS_HISTORY_AVERAGING_TIME +: 5];
    assign out1_format            = fmt1_f;
    assign out2_format            = fmt2_f;
    assign out1_enable            = en1_reg;
    assign out2_enable            = en2_reg;
    assign out1_drive             = drv1_reg;
    assign out2_drive             = drv2_reg;
    assign offset_alarm_reference = aref_oh_reg;

endmodule : csof_regs

// ==== rtl/csof_pkg.sv ====
// Purpose: shared constants and types for the clock select / output format register bank
// Assumes: byte-wide registers at their printed offsets, single 40 MHz clock domain
// Notes:   reserved bits keep their reset value; masks below mark the writable bits
package csof_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_SEL_METHOD   = 8'h04; // selection method and history delay
    localparam logic [7:0] OFS_CMOS_DRIVE   = 8'h05; // single-ended drive strength
    localparam logic [7:0] OFS_OUT_FORMAT   = 8'h06; // output signal formats
    localparam logic [7:0] OFS_ALARM_REF    = 8'h07; // offset alarm reference choice
    localparam logic [7:0] OFS_STATIC_HOLD  = 8'h08; // output static logic hold
    localparam logic [7:0] OFS_HISTORY_AVERAGING_TIME     = 8'h09; // history averaging time

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_SEL_METHOD   = 8'h12;
    localparam logic [7:0] RST_CMOS_DRIVE   = 8'hED;
    localparam logic [7:0] RST_OUT_FORMAT   = 8'h2D;
    localparam logic [7:0] RST_ALARM_REF    = 8'h2A;
    localparam logic [7:0] RST_STATIC_HOLD  = 8'h00;
    localparam logic [7:0] RST_HISTORY_AVERAGING_TIME     = 8'hC0;

    // ************************************************************
    // writable-bit masks, everything else is reserved
    // ************************************************************
    localparam logic [7:0] WR_SEL_METHOD    = 8'hDF; // 7:6 and 4:0
    localparam logic [7:0] WR_CMOS_DRIVE    = 8'hC0; // 7:6
    localparam logic [7:0] WR_OUT_FORMAT    = 8'h3F; // 5:3 and 2:0
    localparam logic [7:0] WR_ALARM_REF     = 8'h07; // 2:0
    localparam logic [7:0] WR_STATIC_HOLD   = 8'hF0; // 7:6 and 5:4
    localparam logic [7:0] WR_HISTORY_AVERAGING_TIME      = 8'hF8; // 7:3

    // ************************************************************
    // field positions (low bit of each field)
    // ************************************************************
    localparam int POS_METHOD    = 6;
    localparam int POS_HISTORY_DELAY  = 0;
    localparam int POS_DRIVE     = 6;
    localparam int POS_OUT2_FMT  = 3;
    localparam int POS_OUT1_FMT  = 0;
    localparam int POS_ALARM_REF = 0;
    localparam int POS_OUT2_HOLD = 6;
    localparam int POS_OUT1_HOLD = 4;
    localparam int POS_HISTORY_AVERAGING_TIME  = 3;

    // ************************************************************
    // field encodings
    // ************************************************************
    localparam logic [1:0] METHOD_MANUAL    = 2'h0;
    localparam logic [1:0] METHOD_NONREVERT = 2'h1;
    localparam logic [1:0] METHOD_REVERT    = 2'h2;
    localparam logic [1:0] CHOICE_IN1       = 2'h0;
    localparam logic [1:0] CHOICE_IN2       = 2'h1;
    localparam logic [2:0] FMT_DISABLE      = 3'h1;
    localparam logic [2:0] FMT_CMOS         = 3'h2;
    localparam logic [2:0] FMT_LVDS_LOW     = 3'h3;
    localparam logic [2:0] FMT_LVPECL       = 3'h5;
    localparam logic [2:0] FMT_CML          = 3'h6;
    localparam logic [2:0] FMT_LVDS         = 3'h7;
    localparam logic [2:0] AREF_EXTERNAL    = 3'h0;
    localparam logic [2:0] AREF_IN1         = 3'h1;
    localparam logic [2:0] AREF_IN2         = 3'h2;
    localparam logic [1:0] HOLD_NORMAL      = 2'h0;
    localparam logic [1:0] HOLD_LOW         = 2'h1;
    localparam logic [1:0] HOLD_HIGH        = 2'h2;

    // input selection state
    typedef enum logic [1:0] {
        SEL_IN1  = 2'b00,
        SEL_IN2  = 2'b01,
        SEL_HOLD = 2'b10
    } csof_sel_t;

    // output hold stage state
    typedef enum logic [1:0] {
        OH_FOLLOW = 2'b00,
        OH_LOW    = 2'b01,
        OH_HIGH   = 2'b10
    } csof_hold_t;

endpackage : csof_pkg

// ==== rtl/csof_out_hold.sv ====
// Purpose: glitch-free static hold stage for one clock output
// Assumes: src_clk is a divided clock made by logic on ref_clk
// Notes:   state changes only when the output already sits at the level of the new state
`timescale 1ns/10ps
module csof_out_hold (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              src_clk,    // clock to pass through
    input  wire logic [1:0]        hold_code,  // requested hold mode
    output logic                   out_level,  // held or passed clock
    output logic                   holding     // a static hold is in force
);
    import csof_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    csof_hold_t state_reg;                     // present mode
    csof_hold_t state_next;                    // next mode
    logic       out_reg;                       // registered output
    logic       out_next;                      // next output

    // next mode: an edge in progress completes before the switch
    always_comb begin
        state_next = state_reg;
        case (hold_code)
            HOLD_NORMAL: begin
                // release only when the source matches the held level, so no runt
                if (src_clk == out_reg) state_next = OH_FOLLOW;
            end
            HOLD_LOW: begin
                // enter low only once the output is low on its own
                if (!out_reg && !src_clk) state_next = OH_LOW;
                // from static high, release first while the source is high too
                else if (state_reg == OH_HIGH && src_clk) state_next = OH_FOLLOW;
            end
            HOLD_HIGH: begin
                // enter high only once the output is high on its own
                if (out_reg && src_clk) state_next = OH_HIGH;
                // from static low, release first while the source is low too
                else if (state_reg == OH_LOW && !src_clk) state_next = OH_FOLLOW;
            end
            default: begin
                // reserved code keeps the present mode
                state_next = state_reg;
            end
        endcase
        case (state_next)
            OH_LOW:  out_next = 1'b0;
            OH_HIGH: out_next = 1'b1;
            default: out_next = src_clk;
        endcase
    end

    // register the mode and the output
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= OH_FOLLOW;
            out_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            out_reg   <= out_next;
        end
    end

    assign out_level = out_reg;
    assign holding   = (state_reg != OH_FOLLOW);

endmodule : csof_out_hold

// ==== bench/csof_host_model.sv ====
// Purpose: host side of the register port, one byte per access
// Assumes: strobes move only just after a rising edge
// Notes:   write data is inverted once the strobe drops, so stale data is never trusted
`timescale 1ns/10ps
module csof_host_model (
    input  wire logic       ref_clk,
    output logic            wr_en   = 1'b0,
    output logic            rd_en   = 1'b0,
    output logic      [7:0] addr    = 8'h00,
    output logic      [7:0] wr_data = 8'h00
);
    // one strobe cycle; a read raises rd_en alone, a write raises wr_en alone
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        {wr_en, rd_en, addr, wr_data} <= {w, !w, a, v};
        @(posedge ref_clk);
        {wr_en, rd_en, wr_data} <= {2'h0, ~v};
    endtask : acc
endmodule : csof_host_model

// ==== bench/csof_regs_checker.sv ====
// Purpose: port assertions for the register bank
// Assumes: one ref_clk domain, synchronous reset
// Notes:   decoded outputs trail their register by one edge
`timescale 1ns/10ps
module csof_regs_checker
    import csof_pkg::*;
(
    input wire logic       ref_clk, reset, wr_en, rd_en, force_hold, digital_hold,
    input wire logic       output_one, output_one_src, out1_enable, out2_enable,
    input wire logic [7:0] addr, wr_data, rd_data,
    input wire logic [4:0] history_delay,
    input wire logic [2:0] out1_format, out2_format, offset_alarm_reference,
    input wire logic [1:0] out1_drive
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic [4:0] wd_low = wr_data[4:0]; // low write bits for the history check
    // write that names input two as alarm reference
    sequence s_aref_wr; wr_en && addr == OFS_ALARM_REF && wr_data[2:0] == AREF_IN2; endsequence
    property p_rsv; rd_en && addr == OFS_CMOS_DRIVE |=> rd_data[5:0] == 6'h2D; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits moved");
    property p_hdel; wr_en && addr == OFS_SEL_METHOD |=> history_delay == $past(wd_low); endproperty
    a_hdel: assert property (p_hdel) else $error("history delay not taken");
    property p_en1; out1_format inside {3'h0, 3'h1, 3'h4} |=> !out1_enable; endproperty
    a_en1: assert property (p_en1) else $error("out1 enabled wrongly");
    property p_en2; out2_format inside {3'h2, 3'h3, 3'h5, 3'h6, 3'h7} |=> out2_enable; endproperty
    a_en2: assert property (p_en2) else $error("out2 not enabled");
    property p_drv; out1_format != 3'h2 |=> out1_drive == 2'h0; endproperty
    a_drv: assert property (p_drv) else $error("drive outside cmos");
    property p_aref; s_aref_wr |-> ##2 offset_alarm_reference == 3'h4; endproperty
    a_aref: assert property (p_aref) else $error("alarm reference wrong");
    property p_fhold; force_hold |=> digital_hold; endproperty
    a_fhold: assert property (p_fhold) else $error("hold not forced");
    property p_glitch; $changed(output_one) |-> output_one == $past(output_one_src); endproperty
    a_glitch: assert property (p_glitch) else $error("output one glitched");
endmodule : csof_regs_checker
bind csof_regs csof_regs_checker chk_u (.ref_clk, .reset, .wr_en, .rd_en, .force_hold, .digital_hold,
    .output_one, .output_one_src, .out1_enable, .out2_enable, .addr, .wr_data, .rd_data, .history_delay,
    .out1_format, .out2_format, .offset_alarm_reference, .out1_drive);

// ==== bench/csof_regs_tb.sv ====
// Purpose: self-checking bench for the register bank
// Assumes: host model carries all register traffic
// Notes:   source clocks are slow so that hold entry can occur
`timescale 1ns/10ps
module csof_regs_tb;
    import csof_pkg::*;
    localparam logic [7:0] RST [6] = '{8'h12, 8'hED, 8'h2D, 8'h2A, 8'h00, 8'hC0};
    localparam logic [7:0] WM [6]  = '{8'hDF, 8'hC0, 8'h3F, 8'h07, 8'hF0, 8'hF8};
    localparam logic [7:0] EN      = 8'hEC; // bit n set when format n drives
    logic       ref_clk = 1'b0, reset = 1'b1;
    logic [8:0] sel_in  = 9'h000; // hold, pin ctl, pin, bad1, bad2, choice, priority
    logic [2:0] div     = 3'h0;
    logic       wr_en, rd_en, use_input_two, digital_hold, out1_enable, out2_enable, output_one, output_two;
    logic [7:0] addr, wr_data, rd_data;
    logic [4:0] history_delay, history_averaging_time;
    logic [2:0] out1_format, out2_format, offset_alarm_reference;
    logic [1:0] out1_drive, out2_drive;
    int         n_mismatch = 0, cmp_count = 0;
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) div <= div + 3'h1;
    csof_host_model host_u (.ref_clk, .wr_en, .rd_en, .addr, .wr_data);
    csof_regs dut_u (.ref_clk, .reset, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .pin_select_control(sel_in[7]),
        .register_input_choice(sel_in[3:2]), .first_priority_input(sel_in[1:0]), .force_hold(sel_in[8]),
        .select_pin(sel_in[6]), .input_one_bad(sel_in[5]), .input_two_bad(sel_in[4]), .output_one_src(div[1]),
        .output_two_src(div[2]), .use_input_two, .digital_hold, .history_delay, .history_averaging_time,
        .out1_format, .out2_format, .out1_enable, .out2_enable, .out1_drive, .out2_drive,
        .offset_alarm_reference, .output_one, .output_two);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : settle
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host_u.acc(1'b0, a, 8'h00);
        #1;
        chk(rd_data, e);
    endtask : rdchk
    // drive selection inputs, then compare hold and input-two flags under a mask
    task automatic sel(input logic [8:0] v, input logic [7:0] e, input logic [7:0] m);
        @(posedge ref_clk) sel_in <= v;
        settle();
        chk({6'h0, digital_hold, use_input_two} & m, e);
    endtask : sel
    task automatic finish_test();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rdchk(8'(4 + i), RST[i]);
            host_u.acc(1'b1, 8'(4 + i), 8'hFF);
            rdchk(8'(4 + i), RST[i] | WM[i]);
            host_u.acc(1'b1, 8'(4 + i), 8'h00);
            rdchk(8'(4 + i), RST[i] & ~WM[i]);
        end
        rdchk(8'h0A, 8'h00);
        host_u.acc(1'b1, OFS_HISTORY_AVERAGING_TIME, 8'hA8);
        settle();
        chk({3'h0, history_averaging_time}, 8'h15);
        host_u.acc(1'b1, OFS_CMOS_DRIVE, 8'h80);
        for (int c = 0; c < 8; c++) begin
            host_u.acc(1'b1, OFS_OUT_FORMAT, {2'h0, 3'(7 - c), 3'(c)});
            host_u.acc(1'b1, OFS_ALARM_REF, 8'(c));
            settle();
            chk({6'h0, out2_enable, out1_enable}, {6'h0, EN[7 - c], EN[c]});
            chk({2'h0, out2_format, out1_format}, {2'h0, 3'(7 - c), 3'(c)});
            chk({4'h0, out2_drive, out1_drive}, (c == 2) ? 8'h02 : (c == 5) ? 8'h08 : 8'h00);
            chk({5'h0, offset_alarm_reference}, (c < 3) ? 8'(1 << c) : 8'h00);
        end
        for (int h = 0; h < 4; h++) begin
            host_u.acc(1'b1, OFS_STATIC_HOLD, (h == 0) ? 8'h50 : (h == 1) ? 8'hA0 : (h == 2) ? 8'h60 : 8'h00);
            repeat (3) settle();
            if (h < 3) chk({6'h0, output_two, output_one}, (h == 1) ? 8'h03 : 8'(h == 2));
        end
        sel(9'h100, 8'h02, 8'h02);
        sel(9'h004, 8'h01, 8'h03);
        sel(9'h084, 8'h00, 8'h03);
        sel(9'h0C4, 8'h01, 8'h03);
        host_u.acc(1'b1, OFS_SEL_METHOD, 8'h95);
        sel(9'h0C4, 8'h00, 8'h03);
        chk({3'h0, history_delay}, 8'h15);
        sel(9'h0C5, 8'h01, 8'h03);
        sel(9'h0D5, 8'h00, 8'h03);
        host_u.acc(1'b1, OFS_SEL_METHOD, 8'h40);
        sel(9'h0C5, 8'h00, 8'h03);
        sel(9'h0F5, 8'h02, 8'h02);
        finish_test();
    end
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (8000) @(posedge ref_clk);
        n_mismatch++;
        finish_test();
    end
endmodule : csof_regs_tb
